// >>> include/cwdp_defines.svh
// Offsets, field positions, reset values and keys for the configuration decoder
`ifndef CWDP_DEFINES_SVH
`define CWDP_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define CWDP_ADR_CFG_B 8'h00
`define CWDP_ADR_CFG_C 8'h04
`define CWDP_ADR_CFG_D 8'h08
`define CWDP_ADR_PART_ID 8'h0c
`define CWDP_ADR_STEP 8'h10
`define CWDP_ADR_OSC_CTRL 8'h14
`define CWDP_ADR_UNLOCK 8'h18
`define CWDP_ADR_IRQ4 8'h1c
`define CWDP_ADR_RST_STAT 8'h20
`define CWDP_ADR_PROBE 8'h24
`define CWDP_ADR_PPS_BASE 8'h40
`define CWDP_ADR_PPS_MASK 8'hc0

// ==========================================================
// Field positions
`define CWDP_SINGLE_SHOT_BIT 4
`define CWDP_RSVD_B_HI 3
`define CWDP_RSVD_B_LO 2
`define CWDP_LOCK_BIT 6
`define CWDP_OPEN_BIT 7
`define CWDP_LVD_BIT 8
`define CWDP_BOR_BIT 1
`define CWDP_PROBE_HIT_BIT 8
`define CWDP_PAGE_BITS 9

// ==========================================================
// Values
`define CWDP_CFG_RESET 16'hffff
`define CWDP_ONES_BYTE 8'hff
`define CWDP_ZERO_BYTE 8'h00
`define CWDP_RSVD_D_VAL 16'hffff
`define CWDP_UNLOCK_KEY1 8'h46
`define CWDP_UNLOCK_KEY2 8'h57

`endif

// >>> include/cwdp_pkg.sv
// Types shared by the configuration decoder files
package cwdp_pkg;

    // ==========================================================
    // Modes
    typedef enum logic [1:0] {
        CWDP_POSC_EXT = 2'h0,
        CWDP_POSC_XT = 2'h1,
        CWDP_POSC_HS = 2'h2,
        CWDP_POSC_OFF = 2'h3
    } cwdp_posc_e;

    typedef enum logic [1:0] {
        CWDP_SOSC_EXT = 2'h0,
        CWDP_SOSC_LOW = 2'h1,
        CWDP_SOSC_RSVD = 2'h2,
        CWDP_SOSC_HIGH = 2'h3
    } cwdp_sosc_e;

    typedef enum logic [2:0] {
        CWDP_UNLK_IDLE = 3'h1,
        CWDP_UNLK_KEY1 = 3'h2,
        CWDP_UNLK_OPEN = 3'h4
    } cwdp_unlk_e;

    // ==========================================================
    // Third configuration word, low sixteen bits
    typedef struct packed {
        logic end_sel;
        logic cfg_open;
        logic seg_dis;
        logic pmp_default;
        logic [1:0] wake;
        cwdp_sosc_e sosc;
        logic [7:0] bound;
    } cwdp_cfgc_s;

endpackage

// >>> src/cwdp_pin_bank.sv
// Pin-select register bank with registered read data
`timescale 1ns/1ps
module cwdp_pin_bank #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW = $clog2(DEPTH)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem_r [DEPTH];

    // ==========================================================
    // Storage
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_word
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    mem_r[gi] <= '0;
                end else if (we && (waddr == AW'(gi))) begin
                    mem_r[gi] <= wdata;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Read register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= '0;
        end else begin
            rdata <= mem_r[raddr];
        end
    end

endmodule

// >>> src/cwdp_top.sv
// Configuration word decoder, segment write protection and part identity
`timescale 1ns/1ps
`include "cwdp_defines.svh"
module cwdp_top #(
    parameter logic [7:0] FAMILY_CODE = 8'h5a, // Arbitrary value
    parameter logic [7:0] MEMBER_CODE = 8'h3c, // Arbitrary value
    parameter logic [3:0] STEPPING = 4'h1, // Arbitrary value
    parameter int ADDR_W = 24,
    parameter logic [7:0] LAST_PAGE = 8'hff,
    parameter bit PIN64 = 1'b0,
    parameter int PPS_DEPTH = 8,
    parameter int PPS_W = 8
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Non-volatile configuration words
    input wire logic [15:0] CFG_WORD_B_IN,
    input wire logic [15:0] CFG_WORD_C_IN,
    input wire logic [15:0] CFG_WORD_D_IN,
    // Program memory write check
    input wire logic NVM_REQ,
    input wire logic [ADDR_W-1:0] NVM_ADDR,
    output logic NVM_GRANT,
    output logic NVM_BLOCKED,
    // Supply monitoring
    input wire logic LVD_TRIP,
    input wire logic SUPPLY_LOW,
    output logic BOR_RESET,
    output logic LOW_SUPPLY_FLAG,
    // Decoded controls
    output logic [3:0] PRI_OSC_SEL,
    output logic [2:0] SEC_OSC_SEL,
    output logic REG_WAKE_FAST,
    output logic PMP_ALT_MAP,
    output logic PIN_SELECT_LOCK,
    output logic CFG_CODE_ERR
);

    localparam int PW = ADDR_W - `CWDP_PAGE_BITS;
    localparam int PA = $clog2(PPS_DEPTH);

    // ==========================================================
    // Decode helpers
    function automatic logic is_pps(input logic [7:0] adr);
        return (adr & `CWDP_ADR_PPS_MASK) == `CWDP_ADR_PPS_BASE
            && adr[7:2] < 6'(PPS_DEPTH + 16);
    endfunction

    function automatic logic [PA-1:0] pps_index(input logic [7:0] adr);
        return PA'(adr[7:2] - 6'h10);
    endfunction

    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Segment membership of a 512-word page
    function automatic logic page_protected(input logic [PW-1:0] page,
                                            input cwdp_pkg::cwdp_cfgc_s c);
        logic [PW-1:0] bound;
        logic [PW-1:0] last;
        logic in_seg;
        logic cfg_forced;
        bound = PW'(c.bound);
        last = PW'(LAST_PAGE);
        if (c.end_sel) begin
            in_seg = (page >= bound) && (page <= last);
        end else begin
            in_seg = page <= bound;
        end
        cfg_forced = c.end_sel || (bound == last);
        return !c.seg_dis
            && (in_seg || ((page == last) && (!c.cfg_open || cfg_forced)));
    endfunction

    // ==========================================================
    // Configuration shadows
    logic cap_done_r;
    logic [15:0] cfg_b_r;
    logic [15:0] cfg_c_r;
    logic [15:0] cfg_d_r;
    cwdp_pkg::cwdp_cfgc_s cfgc;

    // Strap inputs are caught on the first edge after release, not in reset
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            cap_done_r <= 1'b0;
            cfg_b_r <= `CWDP_CFG_RESET;
            cfg_c_r <= `CWDP_CFG_RESET;
            cfg_d_r <= `CWDP_CFG_RESET;
        end else if (!cap_done_r) begin
            cap_done_r <= 1'b1;
            cfg_b_r <= CFG_WORD_B_IN;
            cfg_c_r <= CFG_WORD_C_IN;
            cfg_d_r <= CFG_WORD_D_IN;
        end
    end

    assign cfgc = cwdp_pkg::cwdp_cfgc_s'(cfg_c_r);

    // ==========================================================
    // Bus handshake: request, one cycle of work, then acknowledge
    logic busy_r;
    logic wb_req;
    logic wr_go;
    logic [31:0] rd_data;
    logic [31:0] wdat;

    assign wb_req = WB_CYC_I && WB_STB_I && !busy_r && !WB_ACK_O;
    assign wr_go = busy_r && WB_WE_I;
    assign wdat = lane_merge(32'h0, WB_DAT_I, WB_SEL_I);

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            busy_r <= 1'b0;
            WB_ACK_O <= 1'b0;
        end else begin
            busy_r <= wb_req;
            WB_ACK_O <= busy_r;
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            WB_DAT_O <= 32'h0;
        end else if (busy_r) begin
            WB_DAT_O <= WB_WE_I ? 32'h0 : rd_data;
        end
    end

    // ==========================================================
    // Unlock sequence and pin-select lock
    cwdp_pkg::cwdp_unlk_e unlk_r;
    cwdp_pkg::cwdp_unlk_e unlk_nxt;
    logic lock_r;
    logic single_shot;
    logic wr_unlock;
    logic wr_osc;

    assign single_shot = cfg_b_r[`CWDP_SINGLE_SHOT_BIT];
    assign wr_unlock = wr_go && WB_SEL_I[0] && (WB_ADR_I == `CWDP_ADR_UNLOCK);
    assign wr_osc = wr_go && WB_SEL_I[0] && (WB_ADR_I == `CWDP_ADR_OSC_CTRL);

    always_comb begin
        unlk_nxt = unlk_r;
        unique case (unlk_r)
            cwdp_pkg::CWDP_UNLK_IDLE: begin
                if (wr_unlock && wdat[7:0] == `CWDP_UNLOCK_KEY1) begin
                    unlk_nxt = cwdp_pkg::CWDP_UNLK_KEY1;
                end
            end
            cwdp_pkg::CWDP_UNLK_KEY1: begin
                if (wr_unlock) begin
                    unlk_nxt = (wdat[7:0] == `CWDP_UNLOCK_KEY2) ?
                        cwdp_pkg::CWDP_UNLK_OPEN : cwdp_pkg::CWDP_UNLK_IDLE;
                end else if (wr_go) begin
                    unlk_nxt = cwdp_pkg::CWDP_UNLK_IDLE;
                end
            end
            cwdp_pkg::CWDP_UNLK_OPEN: begin
                // One lock write per sequence
                if (wr_osc || wr_unlock) begin
                    unlk_nxt = cwdp_pkg::CWDP_UNLK_IDLE;
                end
            end
            default: unlk_nxt = cwdp_pkg::CWDP_UNLK_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            unlk_r <= cwdp_pkg::CWDP_UNLK_IDLE;
        end else begin
            unlk_r <= unlk_nxt;
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            lock_r <= 1'b0;
        end else if (wr_osc && unlk_r == cwdp_pkg::CWDP_UNLK_OPEN) begin
            if (!(single_shot && lock_r)) begin
                lock_r <= wdat[`CWDP_LOCK_BIT];
            end
        end
    end

    // ==========================================================
    // Pin-select bank; writes dropped while locked
    logic pps_we;
    logic [PPS_W-1:0] pps_rdata;

    assign pps_we = wr_go && is_pps(WB_ADR_I) && !lock_r;

    cwdp_pin_bank #(
        .WIDTH(PPS_W),
        .DEPTH(PPS_DEPTH)
    ) u_bank (
        .clk(CLK_SYS),
        .arst_n(ARST_N),
        .we(pps_we),
        .waddr(pps_index(WB_ADR_I)),
        .wdata(wdat[PPS_W-1:0]),
        .raddr(pps_index(WB_ADR_I)),
        .rdata(pps_rdata)
    );

    // ==========================================================
    // Supply flags; an event in the clearing cycle keeps the flag
    logic lvd_r;
    logic bor_seen_r;
    logic clr_lvd;
    logic clr_bor;

    assign clr_lvd = wr_go && (WB_ADR_I == `CWDP_ADR_IRQ4) && wdat[`CWDP_LVD_BIT];
    assign clr_bor = wr_go && (WB_ADR_I == `CWDP_ADR_RST_STAT) && wdat[`CWDP_BOR_BIT];

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            lvd_r <= 1'b0;
        end else if (LVD_TRIP) begin
            lvd_r <= 1'b1;
        end else if (clr_lvd) begin
            lvd_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            bor_seen_r <= 1'b0;
        end else if (SUPPLY_LOW) begin
            bor_seen_r <= 1'b1;
        end else if (clr_bor) begin
            bor_seen_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            BOR_RESET <= 1'b0;
            LOW_SUPPLY_FLAG <= 1'b0;
        end else begin
            BOR_RESET <= SUPPLY_LOW;
            LOW_SUPPLY_FLAG <= lvd_r;
        end
    end

    // ==========================================================
    // Program memory write check and software probe
    logic [7:0] probe_page_r;

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            probe_page_r <= 8'h00;
        end else if (wr_go && WB_SEL_I[0] && WB_ADR_I == `CWDP_ADR_PROBE) begin
            probe_page_r <= wdat[7:0];
        end
    end

    // Requests before the words are captured are refused, not guessed
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            NVM_GRANT <= 1'b0;
            NVM_BLOCKED <= 1'b0;
        end else begin
            NVM_GRANT <= NVM_REQ && cap_done_r
                && !page_protected(NVM_ADDR[ADDR_W-1:`CWDP_PAGE_BITS], cfgc);
            NVM_BLOCKED <= NVM_REQ && (!cap_done_r
                || page_protected(NVM_ADDR[ADDR_W-1:`CWDP_PAGE_BITS], cfgc));
        end
    end

    // ==========================================================
    // Decoded controls
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            PRI_OSC_SEL <= 4'h0;
        end else begin
            unique case (cwdp_pkg::cwdp_posc_e'(cfg_b_r[1:0]))
                cwdp_pkg::CWDP_POSC_OFF: PRI_OSC_SEL <= 4'h8;
                cwdp_pkg::CWDP_POSC_HS: PRI_OSC_SEL <= 4'h4;
                cwdp_pkg::CWDP_POSC_XT: PRI_OSC_SEL <= 4'h2;
                cwdp_pkg::CWDP_POSC_EXT: PRI_OSC_SEL <= 4'h1;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            SEC_OSC_SEL <= 3'h0;
        end else begin
            unique case (cfgc.sosc)
                cwdp_pkg::CWDP_SOSC_HIGH: SEC_OSC_SEL <= 3'h4;
                cwdp_pkg::CWDP_SOSC_LOW: SEC_OSC_SEL <= 3'h2;
                cwdp_pkg::CWDP_SOSC_EXT: SEC_OSC_SEL <= 3'h1;
                cwdp_pkg::CWDP_SOSC_RSVD: SEC_OSC_SEL <= 3'h0;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            REG_WAKE_FAST <= 1'b0;
            PMP_ALT_MAP <= 1'b0;
            PIN_SELECT_LOCK <= 1'b0;
            CFG_CODE_ERR <= 1'b0;
        end else begin
            REG_WAKE_FAST <= cfgc.wake == 2'h1;
            // Small package has no alternate map, whatever the word says
            PMP_ALT_MAP <= !PIN64 && !cfgc.pmp_default;
            PIN_SELECT_LOCK <= lock_r;
            CFG_CODE_ERR <= !cfgc.wake[0]
                || cfgc.sosc == cwdp_pkg::CWDP_SOSC_RSVD
                || cfg_d_r != `CWDP_RSVD_D_VAL
                || (PIN64 && !cfgc.pmp_default)
                || !cfg_b_r[`CWDP_RSVD_B_HI]
                || !cfg_b_r[`CWDP_RSVD_B_LO];
        end
    end

    // ==========================================================
    // Read multiplexer
    always_comb begin
        rd_data = 32'h0;
        if (is_pps(WB_ADR_I)) begin
            rd_data = 32'(pps_rdata);
        end else begin
            unique case (WB_ADR_I)
                `CWDP_ADR_CFG_B: rd_data = {8'h00, `CWDP_ONES_BYTE, cfg_b_r};
                `CWDP_ADR_CFG_C: rd_data = {8'h00, `CWDP_ONES_BYTE, cfg_c_r};
                `CWDP_ADR_CFG_D: rd_data = {8'h00, `CWDP_ZERO_BYTE, cfg_d_r};
                `CWDP_ADR_PART_ID: begin
                    rd_data = {8'h00, `CWDP_ONES_BYTE, FAMILY_CODE, MEMBER_CODE};
                end
                `CWDP_ADR_STEP: rd_data = {28'h0, STEPPING};
                `CWDP_ADR_OSC_CTRL: begin
                    rd_data[`CWDP_LOCK_BIT] = lock_r;
                    rd_data[`CWDP_OPEN_BIT] = unlk_r == cwdp_pkg::CWDP_UNLK_OPEN;
                end
                `CWDP_ADR_IRQ4: rd_data[`CWDP_LVD_BIT] = lvd_r;
                `CWDP_ADR_RST_STAT: rd_data[`CWDP_BOR_BIT] = bor_seen_r;
                `CWDP_ADR_PROBE: begin
                    rd_data[7:0] = probe_page_r;
                    rd_data[`CWDP_PROBE_HIT_BIT] = page_protected(PW'(probe_page_r), cfgc);
                end
                default: rd_data = 32'h0;
            endcase
        end
    end

endmodule

// >>> verification/cwdp_checker.sv
// Port-level checks for the configuration decoder
`timescale 1ns/1ps
module cwdp_checker #(
    parameter bit PIN64 = 1'b0
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    // Configuration words
    input wire logic [15:0] CFG_WORD_B_IN,
    input wire logic [15:0] CFG_WORD_C_IN,
    input wire logic [15:0] CFG_WORD_D_IN,
    // Memory check and supply
    input wire logic NVM_REQ,
    input wire logic NVM_GRANT,
    input wire logic NVM_BLOCKED,
    input wire logic LVD_TRIP,
    input wire logic SUPPLY_LOW,
    input wire logic BOR_RESET,
    input wire logic LOW_SUPPLY_FLAG,
    // Decoded controls
    input wire logic [3:0] PRI_OSC_SEL,
    input wire logic [2:0] SEC_OSC_SEL,
    input wire logic REG_WAKE_FAST,
    input wire logic PMP_ALT_MAP,
    input wire logic PIN_SELECT_LOCK,
    input wire logic CFG_CODE_ERR
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);

    // ==========================================================
    // Own copy of the words, taken at the first edge after reset
    logic [1:0] age_r;
    logic [15:0] cap_b_r;
    logic [15:0] cap_c_r;
    logic [15:0] cap_d_r;
    logic ready;
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            age_r <= 2'h0;
        end else if (age_r != 2'h3) begin
            age_r <= age_r + 2'h1;
        end
    end
    always_ff @(posedge CLK_SYS) begin
        if (age_r == 2'h0) begin
            cap_b_r <= CFG_WORD_B_IN;
            cap_c_r <= CFG_WORD_C_IN;
            cap_d_r <= CFG_WORD_D_IN;
        end
    end
    // Decoded outputs settle two edges after release; one spare edge
    assign ready = (age_r == 2'h3);

    // ==========================================================
    // Assertions
    AST_PRI_OSC: assert property (ready |-> PRI_OSC_SEL == 4'h1 << cap_b_r[1:0])
        else $error("primary oscillator select wrong");
    AST_SEC_OSC: assert property (ready |-> SEC_OSC_SEL == ((cap_c_r[9:8] == 2'h2) ? 3'h0 :
        (cap_c_r[9:8] == 2'h3) ? 3'h4 : (cap_c_r[9:8] == 2'h1) ? 3'h2 : 3'h1))
        else $error("secondary oscillator select wrong");
    AST_WAKE: assert property (ready |-> REG_WAKE_FAST == (cap_c_r[11:10] == 2'h1))
        else $error("wake time select wrong");
    AST_ALT_MAP: assert property (ready |-> PMP_ALT_MAP == (!cap_c_r[12] && !PIN64))
        else $error("parallel port map wrong");
    AST_CODE_ERR: assert property (ready |-> CFG_CODE_ERR == (!cap_c_r[10] ||
        cap_c_r[9:8] == 2'h2 || cap_d_r != 16'hffff || (PIN64 && !cap_c_r[12]) ||
        cap_b_r[3:2] != 2'h3)) else $error("reserved code flag wrong");
    AST_NVM_ONE: assert property (NVM_REQ |=> NVM_GRANT != NVM_BLOCKED)
        else $error("memory request not answered once");
    AST_NVM_IDLE: assert property (!NVM_REQ |=> !NVM_GRANT && !NVM_BLOCKED)
        else $error("memory answer without request");
    AST_BOR: assert property (1'b1 |=> BOR_RESET == $past(SUPPLY_LOW))
        else $error("brown-out reset does not follow supply");
    AST_LVD: assert property (LVD_TRIP |-> ##2 LOW_SUPPLY_FLAG)
        else $error("low supply flag not set");
    AST_ONE_SHOT: assert property (cap_b_r[4] && PIN_SELECT_LOCK |=> PIN_SELECT_LOCK)
        else $error("single-shot lock released");

    // ==========================================================
    // Coverage
    cover property (NVM_BLOCKED);
    cover property (NVM_GRANT);
    cover property ($rose(PIN_SELECT_LOCK));
    cover property ($fell(LOW_SUPPLY_FLAG));
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the configuration decoder
`timescale 1ns/1ps
module testbench;
    // ==========================================================
    // Signals
    localparam logic [7:0] FAM = 8'ha5; // Arbitrary value
    localparam logic [7:0] MEM = 8'h69; // Arbitrary value
    localparam logic [3:0] STEP = 4'h7; // Arbitrary value
    logic clk_sys = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic nvm_req = 1'b0, lvd = 1'b0, slow = 1'b0, ack, grant, blocked, bor, lsf;
    logic wfast, altmap, lock, cerr;
    logic [3:0] sel = 4'h0, pri;
    logic [2:0] sec;
    logic [7:0] adr = 8'h00, pg, v;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic [15:0] b = 16'hffff, c = 16'hffff, d = 16'hffff;
    logic [23:0] nvm_addr = 24'h0;
    int errors = 0, comparisons = 0, cycles = 0;

    cwdp_top #(.FAMILY_CODE(FAM), .MEMBER_CODE(MEM), .STEPPING(STEP)) u_cwdp_top (
        .CLK_SYS(clk_sys), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_SEL_I(sel), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .CFG_WORD_B_IN(b), .CFG_WORD_C_IN(c), .CFG_WORD_D_IN(d), .NVM_REQ(nvm_req),
        .NVM_ADDR(nvm_addr), .NVM_GRANT(grant), .NVM_BLOCKED(blocked), .LVD_TRIP(lvd),
        .SUPPLY_LOW(slow), .BOR_RESET(bor), .LOW_SUPPLY_FLAG(lsf), .PRI_OSC_SEL(pri),
        .SEC_OSC_SEL(sec), .REG_WAKE_FAST(wfast), .PMP_ALT_MAP(altmap),
        .PIN_SELECT_LOCK(lock), .CFG_CODE_ERR(cerr));

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    // Whole run is near 2000 cycles; the ceiling leaves ample margin
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            final_report();
        end
    end

    // ==========================================================
    // Tasks and expectations
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Waits for ack under a bound; read data taken at the ack edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dt,
                      input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= dt;
        sel <= s;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (ack !== 1'b1) chk("bus_ack", 32'(ack), 32'h1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0, 4'hf);
        chk($sformatf("read_%h", a), rd & m, e);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic unlock();
        wb(1'b1, 8'h18, 32'h46, 4'h1);
        wb(1'b1, 8'h18, 32'h57, 4'h1);
    endtask
    task automatic nvm(input logic [7:0] p, input logic exp_blk);
        @(posedge clk_sys);
        nvm_req <= 1'b1;
        nvm_addr <= {7'h0, p, 9'($urandom)};
        @(posedge clk_sys);
        nvm_req <= 1'b0;
        @(negedge clk_sys);
        chk($sformatf("blocked_%h", p), 32'(blocked), 32'(exp_blk));
        chk("grant", 32'(grant), 32'(!exp_blk));
    endtask
    function automatic logic [2:0] sosc_exp(input logic [1:0] s);
        return (s == 2'h3) ? 3'h4 : (s == 2'h1) ? 3'h2 : (s == 2'h0) ? 3'h1 : 3'h0;
    endfunction
    // Last page is also the configuration page here
    function automatic logic prot_exp(input logic [15:0] w, input logic [7:0] p);
        logic ins;
        ins = w[15] ? (p >= w[7:0]) : (p <= w[7:0]);
        return !w[13] && (ins || (p == 8'hff && (!w[14] || w[15] || w[7:0] == 8'hff)));
    endfunction

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'hbbed8a2d));
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            b <= {16'($urandom)} & 16'hffe0 | {11'h0, i[2], (i == 5) ? 2'h1 : 2'h3, i[1:0]};
            c <= {16'($urandom)} & 16'h90ff | {1'b0, i[0], i == 6, 1'b0, 2'(i + 1), i[1:0], 8'h0};
            d <= (i == 3) ? 16'hfffe : 16'hffff;
            arst_n <= 1'b0;
            repeat (15) @(posedge clk_sys);
            if (i == 0) c[7:0] <= 8'hff;
            if (i == 1) c[7:0] <= 8'h00;
            if (i == 2) c[15] <= 1'b1;
            @(posedge clk_sys);
            arst_n <= 1'b1;
            settle();
            settle();
            chk("pri_osc", 32'(pri), 32'h1 << b[1:0]);
            chk("sec_osc", 32'(sec), 32'(sosc_exp(c[9:8])));
            chk("wake_fast", 32'(wfast), 32'(c[11:10] == 2'h1));
            chk("alt_map", 32'(altmap), 32'(!c[12]));
            chk("code_err", 32'(cerr), 32'(!c[10] || c[9:8] == 2'h2 || d != 16'hffff || b[3:2] != 2'h3));
            wb(1'b1, 8'h0c, 32'h0, 4'hf);
            wb(1'b1, 8'h10, 32'hffffffff, 4'hf);
            rdchk(8'h04, 32'hffffff, {8'hff, c});
            rdchk(8'h08, 32'hffffff, {8'h00, d});
            rdchk(8'h0c, 32'hff00, {16'h0, FAM, 8'h00});
            rdchk(8'h0c, 32'hff, {24'h0, MEM});
            rdchk(8'h10, 32'hffffff, {20'h0, STEP});
            rdchk(8'h30, 32'hffffffff, 32'h0);
            for (int k = 0; k < 10; k++) begin
                pg = (k == 0) ? c[7:0] : (k == 1) ? c[7:0] - 8'h1 : (k == 2) ? c[7:0] + 8'h1 :
                     (k == 3) ? 8'h00 : (k == 4) ? 8'hff : 8'($urandom);
                nvm(pg, prot_exp(c, pg));
                wb(1'b1, 8'h24, {24'h0, pg}, 4'h1);
                rdchk(8'h24, 32'h1ff, {23'h0, prot_exp(c, pg), pg});
            end
            v = 8'($urandom);
            wb(1'b1, 8'h40, {24'h0, v}, 4'h1);
            wb(1'b1, 8'h14, 32'h40, 4'h1);
            settle();
            chk("lock_no_key", 32'(lock), 32'h0);
            unlock();
            rdchk(8'h14, 32'hc0, 32'h80);
            wb(1'b1, 8'h14, 32'h40, 4'h1);
            settle();
            chk("lock_set", 32'(lock), 32'h1);
            wb(1'b1, 8'h40, {24'h0, ~v}, 4'h1);
            rdchk(8'h40, 32'hff, {24'h0, v});
            unlock();
            wb(1'b1, 8'h14, 32'h0, 4'h1);
            settle();
            chk("lock_clear", 32'(lock), 32'(b[4]));
            @(posedge clk_sys);
            lvd <= 1'b1;
            @(posedge clk_sys);
            lvd <= 1'b0;
            settle();
            chk("lvd_flag", 32'(lsf), 32'h1);
            rdchk(8'h1c, 32'h100, 32'h100);
            wb(1'b1, 8'h1c, 32'h100, 4'h2);
            settle();
            chk("lvd_clear", 32'(lsf), 32'h0);
            @(posedge clk_sys);
            slow <= 1'b1;
            @(posedge clk_sys);
            slow <= 1'b0;
            @(negedge clk_sys);
            chk("bor", 32'(bor), 32'h1);
            rdchk(8'h20, 32'h2, 32'h2);
            wb(1'b1, 8'h20, 32'h2, 4'h1);
            rdchk(8'h20, 32'h2, 32'h0);
            @(posedge clk_sys);
            b <= ~b;
            c <= ~c;
            settle();
            chk("pri_held", 32'(pri), 32'h1 << (~b[1:0]));
            chk("sec_held", 32'(sec), 32'(sosc_exp(~c[9:8])));
        end
        final_report();
    end
endmodule

bind cwdp_top cwdp_checker #(.PIN64(PIN64)) u_cwdp_checker (
    .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .CFG_WORD_B_IN(CFG_WORD_B_IN),
    .CFG_WORD_C_IN(CFG_WORD_C_IN), .CFG_WORD_D_IN(CFG_WORD_D_IN), .NVM_REQ(NVM_REQ),
    .NVM_GRANT(NVM_GRANT), .NVM_BLOCKED(NVM_BLOCKED), .LVD_TRIP(LVD_TRIP),
    .SUPPLY_LOW(SUPPLY_LOW), .BOR_RESET(BOR_RESET), .LOW_SUPPLY_FLAG(LOW_SUPPLY_FLAG),
    .PRI_OSC_SEL(PRI_OSC_SEL), .SEC_OSC_SEL(SEC_OSC_SEL), .REG_WAKE_FAST(REG_WAKE_FAST),
    .PMP_ALT_MAP(PMP_ALT_MAP), .PIN_SELECT_LOCK(PIN_SELECT_LOCK), .CFG_CODE_ERR(CFG_CODE_ERR));
